// ### rtl/cszt_pkg.sv
// Constants, types and lookup for the HS-zero timing control register
// Summary of operation
// - Bit 7 is the override select, reset to zero, picking automatic or software HS-zero timing.
// - With override clear, the block computes HS-zero timing from the lane rate and uses it.
// - With override clear, the 7-bit field reads back the automatic value and is read-only.
// - With override set, the HS-zero timing output is driven from the 7-bit field.
// - With override set, the 7-bit field takes software writes and reads back the stored value.
// - The field resets to 0x0C, the 800 Mbps setting, and tracks any newly selected known lane rate (codes 0 to 4) while override is clear.
`default_nettype none

package cszt_pkg;

  typedef enum logic [2:0] {
    CSZT_RATE_400,
    CSZT_RATE_800,
    CSZT_RATE_1200,
    CSZT_RATE_1500,
    CSZT_RATE_1600
  } cszt_rate_t;

  localparam logic [7:0] CSZT_REG_OFFSET = 8'h45;
  localparam int CSZT_OVR_BIT = 7;
  localparam int CSZT_VAL_MSB = 6;
  localparam logic CSZT_OVR_RESET = 1'b0;
  localparam logic [6:0] CSZT_VAL_RESET = 7'h0C;
  localparam logic [7:0] CSZT_RDATA_IDLE = 8'h00;
  localparam logic [7:0] CSZT_RDATA_UNMAPPED = 8'h00;
  localparam logic [2:0] CSZT_RATE_RESET = 3'h1;

  // Automatic HS-zero settings per lane rate
  localparam logic [6:0] CSZT_AUTO_400 = 7'h06;
  localparam logic [6:0] CSZT_AUTO_800 = 7'h0C;
  localparam logic [6:0] CSZT_AUTO_1200 = 7'h12;
  localparam logic [6:0] CSZT_AUTO_1500 = 7'h16;
  localparam logic [6:0] CSZT_AUTO_1600 = 7'h18;

  // Unknown rate codes keep the previous setting
  function automatic logic [6:0] cszt_auto_lookup(
    input logic [2:0] sel,
    input logic [6:0] prev
  );
    logic [6:0] val;
    val = prev;
    case (sel)
      CSZT_RATE_400: val = CSZT_AUTO_400;
      CSZT_RATE_800: val = CSZT_AUTO_800;
      CSZT_RATE_1200: val = CSZT_AUTO_1200;
      CSZT_RATE_1500: val = CSZT_AUTO_1500;
      CSZT_RATE_1600: val = CSZT_AUTO_1600;
      default: val = prev;
    endcase
    return val;
  endfunction

endpackage

`default_nettype wire

// ### rtl/cszt_rate_if.sv
// Lane rate and automatic HS-zero value between control and calculator
`default_nettype none

interface cszt_rate_if;
  logic [2:0] rate_sel;
  logic [6:0] auto_value;
  logic rate_update;

  modport calc (
    input rate_sel,
    output auto_value,
    output rate_update
  );

  modport ctl (
    output rate_sel,
    input auto_value,
    input rate_update
  );
endinterface

`default_nettype wire

// ### rtl/cszt_auto_calc.sv
// Automatic HS-zero value from the selected lane rate
`default_nettype none

module cszt_auto_calc
  import cszt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  cszt_rate_if.calc rate
);

  logic [6:0] auto_reg;
  logic [6:0] auto_next;
  logic [2:0] sel_reg;
  logic [2:0] sel_next;
  logic update_reg;
  logic update_next;

  //////////////////////////////////////////////////////////////////////////
  // Next value from rate table
  always_comb begin
    sel_next = rate.rate_sel;
    auto_next = cszt_auto_lookup(rate.rate_sel, auto_reg);
    update_next = (rate.rate_sel != sel_reg) && (auto_next != auto_reg);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_reg <= CSZT_VAL_RESET;
      sel_reg <= CSZT_RATE_RESET;
      update_reg <= 1'b0;
    end else begin
      auto_reg <= auto_next;
      sel_reg <= sel_next;
      update_reg <= update_next;
    end
  end

  assign rate.auto_value = auto_reg;
  assign rate.rate_update = update_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  AST_AUTO_TABLE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rate.rate_sel inside {[3'h0:3'h4]})
      |=> rate.auto_value == cszt_auto_lookup($past(rate.rate_sel), 7'h00))
    else $error("Automatic value does not match selected lane rate");

  AST_AUTO_800: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rate.rate_sel == CSZT_RATE_800) [*2] |-> rate.auto_value == 7'h0C)
    else $error("Automatic value at 800 Mbps is not 0x0C");

endmodule

`default_nettype wire

// ### rtl/cszt_timing_ctl.sv
// HS-zero timing control register with automatic and override modes
//
// Local design decision: strobed register access.
`default_nettype none

module cszt_timing_ctl
  import cszt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic [2:0] lane_rate_sel,
  output logic [6:0] hs_zero_timing,
  output logic hs_zero_override_en,
  output logic hs_zero_auto_update
);

  cszt_rate_if rate ();

  logic override_reg;
  logic override_next;
  logic [6:0] value_reg;
  logic [6:0] value_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic addr_hit;
  logic wr_hit;
  logic rd_hit;

  //////////////////////////////////////////////////////////////////////////
  // Automatic value calculator
  assign rate.rate_sel = lane_rate_sel;

  cszt_auto_calc u_auto_calc (
    .clk(clk),
    .reset_n(reset_n),
    .rate(rate.calc)
  );

  //////////////////////////////////////////////////////////////////////////
  // Address decode
  assign addr_hit = (reg_addr == CSZT_REG_OFFSET);
  assign wr_hit = reg_wr && addr_hit;
  assign rd_hit = reg_rd && addr_hit;

  //////////////////////////////////////////////////////////////////////////
  // Override select and value field
  always_comb begin
    override_next = override_reg;
    value_next = value_reg;
    if (wr_hit) begin
      override_next = reg_wdata[CSZT_OVR_BIT];
    end
    if (wr_hit && reg_wdata[CSZT_OVR_BIT]) begin
      value_next = reg_wdata[CSZT_VAL_MSB:0];
    end else if (wr_hit) begin
      value_next = rate.auto_value;
    end else if (!override_reg) begin
      value_next = rate.auto_value;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      override_reg <= CSZT_OVR_RESET;
      value_reg <= CSZT_VAL_RESET;
    end else begin
      override_reg <= override_next;
      value_reg <= value_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path, data in the cycle after the strobe only
  always_comb begin
    rdata_next = CSZT_RDATA_IDLE;
    rd_valid_next = reg_rd;
    if (rd_hit) begin
      rdata_next = {override_reg, value_reg};
    end else if (reg_rd) begin
      rdata_next = CSZT_RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= CSZT_RDATA_IDLE;
      rd_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign hs_zero_timing = value_reg;
  assign hs_zero_override_en = override_reg;
  assign hs_zero_auto_update = rate.rate_update && !override_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  AST_OVR_RESET: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> !hs_zero_override_en)
    else $error("Override select not clear after reset");

  AST_OVR_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_hit |=> hs_zero_override_en == $past(reg_wdata[7]))
    else $error("Override select did not take written bit");

  AST_OVR_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    !wr_hit |=> $stable(hs_zero_override_en))
    else $error("Override select changed without a write");

  AST_AUTO_FOLLOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit) |=>
      hs_zero_timing == $past(rate.auto_value))
    else $error("Timing does not follow automatic value");

  AST_AUTO_RATE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit && lane_rate_sel == CSZT_RATE_1600) [*3]
      |-> hs_zero_timing == CSZT_AUTO_1600)
    else $error("Automatic timing wrong for selected lane rate");

  AST_READ_AUTO: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_hit && !override_reg) |=>
      reg_rdata == {1'b0, $past(value_reg)} && reg_rd_valid)
    else $error("Read in auto mode did not return automatic value");

  AST_READ_AUTO_LIVE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit) ##1 (rd_hit && !override_reg) |=>
      reg_rdata[6:0] == $past(rate.auto_value, 2))
    else $error("Read in auto mode is stale");

  AST_OVR_STEADY: assert property (
    @(posedge clk) disable iff (!reset_n)
    (override_reg && !wr_hit) |=> $stable(hs_zero_timing))
    else $error("Override timing moved without a write");

  AST_OVR_IGNORES_RATE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && reg_wdata[7]) ##1 (!wr_hit) [*3] |->
      hs_zero_timing == $past(reg_wdata[6:0], 3))
    else $error("Override timing lost programmed value");

  AST_FIELD_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && reg_wdata[7]) |=> value_reg == $past(reg_wdata[6:0]))
    else $error("Field write with override set was not stored");

  AST_FIELD_READBACK: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && reg_wdata[7]) ##1 (rd_hit && !reg_wr) |=>
      reg_rdata == {1'b1, $past(reg_wdata[6:0], 2)})
    else $error("Readback in override mode differs from write");

  AST_VAL_RESET: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> hs_zero_timing == 7'h0C)
    else $error("Value field not 0x0C after reset");

  AST_RATE_UPDATE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit && $changed(lane_rate_sel)
      && lane_rate_sel inside {[3'h0:3'h4]}) ##1 (!wr_hit)
      |=> hs_zero_timing == cszt_auto_lookup($past(lane_rate_sel, 2),
        7'h00))
    else $error("Automatic value missed a lane rate change");

  AST_WR_IGNORED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && !reg_wdata[7]) |=>
      hs_zero_timing == $past(rate.auto_value))
    else $error("Field write took effect in auto mode");

  AST_RD_PULSE: assert property (
    @(posedge clk) disable iff (!reset_n)
    !reg_rd |=> !reg_rd_valid && reg_rdata == 8'h00)
    else $error("Read data standing outside answer cycle");

  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (reg_rd && !addr_hit) |=> reg_rd_valid && reg_rdata == 8'h00)
    else $error("Unmapped read did not return zero");

  AST_RD_VALID: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_rd |=> reg_rd_valid)
    else $error("Read strobe gave no valid flag");

  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (!reset_n)
    !reg_rd_valid |-> reg_rdata == 8'h00)
    else $error("Read data not zero outside answer cycle");

  AST_WR_NO_ANSWER: assert property (
    @(posedge clk) disable iff (!reset_n)
    (reg_wr && !reg_rd) |=> !reg_rd_valid)
    else $error("Write produced a read answer");

  AST_OVR_SET: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && reg_wdata[7]) |=> hs_zero_override_en)
    else $error("Override select not set by write");

  AST_OVR_CLEAR: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && !reg_wdata[7]) |=> !hs_zero_override_en)
    else $error("Override select not cleared by write");

  AST_OVR_UNMAPPED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (reg_wr && !addr_hit) |=> $stable(hs_zero_override_en))
    else $error("Unmapped write changed override select");

  AST_READ_OVR_BIT: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_hit |=> reg_rdata[7] == $past(hs_zero_override_en))
    else $error("Read override bit differs from select");

  AST_AUTO_400: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit && lane_rate_sel == CSZT_RATE_400) [*3]
      |-> hs_zero_timing == CSZT_AUTO_400)
    else $error("Automatic timing wrong at 400 Mbps");

  AST_AUTO_1200: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit && lane_rate_sel == CSZT_RATE_1200) [*3]
      |-> hs_zero_timing == CSZT_AUTO_1200)
    else $error("Automatic timing wrong at 1200 Mbps");

  AST_AUTO_1500: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit && lane_rate_sel == CSZT_RATE_1500) [*3]
      |-> hs_zero_timing == CSZT_AUTO_1500)
    else $error("Automatic timing wrong at 1500 Mbps");

  AST_AUTO_800_OUT: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit && lane_rate_sel == CSZT_RATE_800) [*3]
      |-> hs_zero_timing == CSZT_AUTO_800)
    else $error("Automatic timing wrong at 800 Mbps");

  AST_READ_FIELD: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_hit |=> reg_rdata[6:0] == $past(hs_zero_timing))
    else $error("Read field differs from timing in use");

  AST_OVR_WR_TIMING: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && reg_wdata[7]) |=> hs_zero_timing == $past(reg_wdata[6:0]))
    else $error("Override write did not reach timing output");

  AST_OVR_NO_PULSE: assert property (
    @(posedge clk) disable iff (!reset_n)
    override_reg |-> !hs_zero_auto_update)
    else $error("Update pulse while override set");

  AST_READ_OVR: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rd_hit && override_reg) |=> reg_rdata == {1'b1, $past(value_reg)})
    else $error("Read in override mode did not return stored value");

  AST_UNKNOWN_RATE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (lane_rate_sel inside {[3'h5:3'h7]}) |=> $stable(rate.auto_value))
    else $error("Unknown rate code moved automatic value");

  AST_PULSE_CAUSE: assert property (
    @(posedge clk) disable iff (!reset_n)
    hs_zero_auto_update |-> $changed(rate.auto_value))
    else $error("Update pulse without a new automatic value");

  AST_PULSE_ON_CHANGE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!override_reg && !wr_hit && $changed(lane_rate_sel)
      && lane_rate_sel inside {[3'h0:3'h4]}
      && cszt_auto_lookup(lane_rate_sel, 7'h00) != rate.auto_value)
      |=> hs_zero_auto_update)
    else $error("No update pulse after lane rate change");

endmodule

`default_nettype wire

// ### verif/test_cszt_timing_ctl.sv
// Self-checking testbench for the HS-zero timing control register
`default_nettype none

module test_cszt_timing_ctl
  import cszt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rd_valid;
  logic [2:0] lane_rate_sel = 3'h1;
  logic [6:0] hs_zero_timing;
  logic hs_zero_override_en;
  logic hs_zero_auto_update;
  int bad_count = 0;
  int check_count = 0;
  logic [2:0] rate_tab [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
  logic [7:0] auto_tab [6] = '{8'h06, 8'h12, 8'h16, 8'h18, 8'h18, 8'h0C};
  logic [7:0] pulse_tab [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01};
  logic [7:0] pulse_seen;

  cszt_timing_ctl dut (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .lane_rate_sel(lane_rate_sel),
    .hs_zero_timing(hs_zero_timing),
    .hs_zero_override_en(hs_zero_override_en),
    .hs_zero_auto_update(hs_zero_auto_update)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("Test %s done", name);
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read, compare data and valid flag in the answer cycle
  task automatic check_read(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
    check({7'h00, reg_rd_valid}, 8'h01);
  endtask

  task automatic check_out(input logic [7:0] exp);
    check({hs_zero_override_en, hs_zero_timing}, exp);
  endtask

  // New rate, then watch the update pulse over a fixed span
  task automatic set_rate(input logic [2:0] code);
    @(posedge clk);
    lane_rate_sel <= code;
    pulse_seen = 8'h00;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (hs_zero_auto_update === 1'b1) begin
        pulse_seen = 8'h01;
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check_out(8'h0C);
    check_read(CSZT_REG_OFFSET, 8'h0C);
    end_test("reset");

    reg_write(8'h46, 8'h95);
    check_out(8'h0C);
    check_read(8'h46, 8'h00);
    @(posedge clk);
    #1;
    check({reg_rd_valid, reg_rdata[6:0]}, 8'h00);
    end_test("unmapped");

    reg_write(CSZT_REG_OFFSET, 8'h55);
    repeat (2) @(posedge clk);
    #1;
    check_out(8'h0C);
    check_read(CSZT_REG_OFFSET, 8'h0C);
    end_test("auto_write");

    for (int i = 0; i < 6; i++) begin
      set_rate(rate_tab[i]);
      check_out(auto_tab[i]);
      check(pulse_seen, pulse_tab[i]);
      check_read(CSZT_REG_OFFSET, auto_tab[i]);
    end
    end_test("rates");

    reg_write(CSZT_REG_OFFSET, 8'h95);
    check_out(8'h95);
    check_read(CSZT_REG_OFFSET, 8'h95);
    set_rate(3'h4);
    check_out(8'h95);
    check(pulse_seen, 8'h00);
    reg_write(CSZT_REG_OFFSET, 8'hFF);
    check_out(8'hFF);
    check_read(CSZT_REG_OFFSET, 8'hFF);
    reg_write(CSZT_REG_OFFSET, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check_out(8'h18);
    check_read(CSZT_REG_OFFSET, 8'h18);
    end_test("override");

    reg_write(CSZT_REG_OFFSET, 8'hAA);
    set_rate(3'h1);
    check_out(8'hAA);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_out({CSZT_OVR_RESET, CSZT_VAL_RESET});
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_out(8'h0C);
    check_read(CSZT_REG_OFFSET, 8'h0C);
    end_test("second_reset");

    test_done();
  end
endmodule

`default_nettype wire
